/* dram_host_pkg.sv */
// package: timing constants, command codes and state encoding for the dram host controller
package dram_host_pkg;
  localparam int unsigned clk_mhz = 40;
  localparam int unsigned clk_ns = 25;
  // device figures, ns unless stated
  localparam int unsigned row_access_time_ns = 80;
  localparam int unsigned address_access_time_ns = 40;
  localparam int unsigned column_access_time_ns = 25;
  localparam int unsigned precharge_access_time_ns = 50;
  localparam int unsigned test_access_extra_ns = 5;
  localparam int unsigned row_column_strobe_delay_ns = 55;
  localparam int unsigned row_column_address_delay_ns = 40;
  localparam int unsigned row_precharge_ns = 60;
  localparam int unsigned row_strobe_width_ns = 80;
  localparam int unsigned column_strobe_width_ns = 25;
  localparam int unsigned page_cycle_time_ns = 55;
  localparam int unsigned page_column_precharge_ns = 10;
  localparam int unsigned page_row_strobe_width_ns = 100000;
  localparam int unsigned refresh_column_setup_ns = 10;
  localparam int unsigned refresh_column_hold_ns = 20;
  localparam int unsigned test_write_hold_ns = 20;
  localparam int unsigned counter_check_precharge_ns = 40;
  localparam int unsigned rmw_cycle_time_ns = 210;
  localparam int unsigned row_to_write_delay_ns = 110;
  localparam int unsigned column_to_write_delay_ns = 55;
  localparam int unsigned address_to_write_delay_ns = 70;
  localparam int unsigned write_hold_ns = 15;
  localparam int unsigned oe_hold_from_write_ns = 25;
  localparam int unsigned init_pause_us = 100;
  localparam int unsigned init_refresh_count = 8;
  localparam int unsigned refresh_rows = 1024;
  localparam int unsigned refresh_interval_ms = 128;

  // least times round up to whole cycles, never below one
  function automatic int unsigned min_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + clk_ns - 1) / clk_ns;
    return (c == 0) ? 1 : c;
  endfunction
  // longest times round down, never below one
  function automatic int unsigned max_cyc(input int unsigned ns);
    int unsigned c;
    c = ns / clk_ns;
    return (c == 0) ? 1 : c;
  endfunction

  localparam int unsigned cnt_w = 16;
  localparam logic [cnt_w-1:0] row_addr_cyc = cnt_w'(min_cyc(row_column_address_delay_ns) - 1);
  // column address, write strobe and data lead the column strobe by a cycle, so nothing moves with it
  localparam logic [cnt_w-1:0] col_setup_cyc = cnt_w'(1);
  localparam logic [cnt_w-1:0] cas_low_cyc =
    cnt_w'(min_cyc(address_access_time_ns + test_access_extra_ns) + 1);
  localparam logic [cnt_w-1:0] cas_high_cyc = cnt_w'(min_cyc(counter_check_precharge_ns));
  localparam logic [cnt_w-1:0] ras_pre_cyc = cnt_w'(min_cyc(row_precharge_ns));
  localparam logic [cnt_w-1:0] ras_low_cyc = cnt_w'(min_cyc(row_strobe_width_ns));
  localparam logic [cnt_w-1:0] refresh_setup_cyc = cnt_w'(min_cyc(refresh_column_setup_ns));
  localparam logic [cnt_w-1:0] refresh_hold_cyc =
    cnt_w'(min_cyc(refresh_column_hold_ns > test_write_hold_ns ? refresh_column_hold_ns : test_write_hold_ns));
  localparam logic [cnt_w-1:0] rmw_write_cyc =
    cnt_w'(min_cyc(column_to_write_delay_ns > address_to_write_delay_ns ?
                   column_to_write_delay_ns : address_to_write_delay_ns));
  localparam logic [cnt_w-1:0] rmw_total_cyc = cnt_w'(min_cyc(rmw_cycle_time_ns));
  localparam logic [cnt_w-1:0] write_hold_cyc = cnt_w'(min_cyc(write_hold_ns > oe_hold_from_write_ns ?
                                                               write_hold_ns : oe_hold_from_write_ns));
  localparam logic [cnt_w-1:0] page_limit_cyc = cnt_w'(max_cyc(page_row_strobe_width_ns) - 8);
  localparam int unsigned init_pause_cyc = init_pause_us * clk_mhz;
  localparam int unsigned refresh_gap_cyc = (refresh_interval_ms * 1000 * clk_mhz) / refresh_rows;

  // host command codes
  typedef enum logic [2:0] {
    cmd_read,
    cmd_write,
    cmd_rmw,
    cmd_test_enter,
    cmd_test_exit,
    cmd_row_refresh
  } cmd_e;

  typedef enum logic [3:0] {
    st_pause,
    st_idle,
    st_row,
    st_col,
    st_cas_low,
    st_rmw_wait,
    st_write_hold,
    st_cas_high,
    st_ref_setup,
    st_ref_hold,
    st_ras_high
  } state_e;
endpackage

/* dram_host.sv */
// dram host controller: sequences strobes, address and data for a 1m x 4 dynamic memory
// Summary of operation
// - row half then column half on shared lines, latched by row and column strobes
// - write data referenced to column strobe (early) or write strobe (delayed, rmw)
// - output gate turns device outputs off before host drives write data
// - read-modify-write cycle lasts at least its minimum cycle time
// - page mode row strobe low no longer than the page maximum width
// - page accesses spaced by page cycle time with column precharge between
// - column-first refresh: column strobe down before row strobe, held after
// - after power-up wait the pause then eight refresh cycles before accesses
// - initialisation refreshes are all column-first to prime the internal counter
// - test entry write strobe set up before row strobe falls and held after
// - in test mode refresh with reads or write-qualified column-first refresh
// - leave test mode with row-only or plain column-first refresh
// - column precharge between refresh and access at least counter-check precharge
// - all 1,024 rows refreshed within the 128 ms interval
module dram_host
  import dram_host_pkg::*;
#(
  parameter int unsigned init_pause_p = dram_host_pkg::init_pause_cyc, // power-up pause cycles
  parameter int unsigned refresh_gap_p = dram_host_pkg::refresh_gap_cyc, // cycles between refreshes
  parameter int unsigned page_limit_p = 32'(dram_host_pkg::page_limit_cyc) // page row strobe cap
) (
  input wire logic clk, // 40 mhz clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic req_valid, // request present
  output logic req_ready, // request taken this cycle
  input wire dram_host_pkg::cmd_e req_cmd, // command
  input wire logic [19:0] req_addr, // row in [19:10], column in [9:0]
  input wire logic [3:0] req_wdata, // write data
  input wire logic [3:0] req_mask, // rmw: bits to invert in read data
  output logic rsp_valid, // read data valid pulse
  output logic [3:0] rsp_rdata, // read data
  output logic busy, // initialisation or refresh active
  output logic test_mode, // device held in test mode
  output logic ras_n, // row strobe
  output logic cas_n, // column strobe
  output logic we_n, // write strobe
  output logic oe_n, // output gate
  output logic [9:0] addr, // multiplexed address
  output logic [3:0] dq_out, // data lines out
  output logic [3:0] dq_oe, // data line drive enables
  input wire logic [3:0] dq_in // data lines in
);
  import dram_host_pkg::*;

  typedef struct packed {
    state_e st;
    cmd_e cmd;
    logic [19:0] a;
    logic [3:0] wd;
    logic [3:0] mask;
    logic [cnt_w-1:0] cnt;
    logic [cnt_w-1:0] rmw_cnt;
    logic [31:0] timer;
    logic [31:0] ref_timer;
    logic [3:0] init_left;
    logic ref_due;
    logic refreshing;
    logic test;
    logic page_open;
    logic [9:0] open_row;
    logic [31:0] page_cnt;
    logic ras_n, cas_n, we_n, oe_n;
    logic [9:0] addr;
    logic [3:0] dq_out;
    logic dq_drive;
    logic rsp_valid;
    logic [3:0] rsp_rdata;
  } ctl_s;

  ctl_s q, d;
  logic close_page;

  // ---------------------------------------------------------------
  // request handshake
  // ---------------------------------------------------------------
  // an open page shuts for refresh, init, its width cap, another row or a non-access command
  assign close_page = q.page_open && (q.ref_due || q.init_left != 4'h0 || q.page_cnt >= page_limit_p ||
    (req_valid && (req_cmd > cmd_rmw || req_addr[19:10] != q.open_row)));
  // ready only when idle will really take the request, else it would be lost
  assign req_ready = (q.st == st_idle) && !close_page && !q.ref_due && (q.init_left == 4'h0) && req_valid;
  assign busy = (q.st == st_pause) || (q.init_left != 4'h0) || q.refreshing;
  assign test_mode = q.test;
  assign ras_n = q.ras_n;
  assign cas_n = q.cas_n;
  assign we_n = q.we_n;
  assign oe_n = q.oe_n;
  assign addr = q.addr;
  assign dq_out = q.dq_out;
  assign dq_oe = {4{q.dq_drive}};
  assign rsp_valid = q.rsp_valid;
  assign rsp_rdata = q.rsp_rdata;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    d.cnt = (q.cnt != '0) ? q.cnt - 1'b1 : q.cnt;
    d.rmw_cnt = (q.rmw_cnt != '0) ? q.rmw_cnt - 1'b1 : q.rmw_cnt;
    // periodic refresh request, so every row is visited within the interval
    if (q.ref_timer == 32'h0000_0000) begin
      d.ref_timer = refresh_gap_p - 1;
      d.ref_due = 1'b1;
    end else begin
      d.ref_timer = q.ref_timer - 1;
    end
    // page kept open only up to its width cap
    if (q.page_open) begin
      d.page_cnt = q.page_cnt + 1;
    end
    unique case (q.st)
      st_pause: begin
        d.timer = q.timer + 1;
        if (q.timer >= init_pause_p) begin
          d.st = st_idle;
          d.init_left = 4'(init_refresh_count);
        end
      end
      st_idle: begin
        if (close_page) begin
          d.ras_n = 1'b1;
          d.page_open = 1'b0;
          d.cnt = ras_pre_cyc;
          d.st = st_ras_high;
        end else if (q.init_left != 4'h0 || q.ref_due) begin
          // init and periodic refresh are column-first, advancing the device counter
          d.refreshing = 1'b1;
          d.cmd = cmd_test_exit;
          d.we_n = !q.test;
          d.cas_n = 1'b0;
          d.cnt = refresh_setup_cyc;
          d.st = st_ref_setup;
        end else if (req_valid) begin
          d.cmd = req_cmd;
          d.a = req_addr;
          d.wd = req_wdata;
          d.mask = req_mask;
          if (req_cmd == cmd_test_enter || req_cmd == cmd_test_exit) begin
            d.we_n = (req_cmd != cmd_test_enter);
            d.cas_n = 1'b0;
            d.cnt = refresh_setup_cyc;
            d.st = st_ref_setup;
          end else if (q.page_open) begin
            d.addr = req_addr[9:0];
            d.cnt = col_setup_cyc;
            d.st = st_col;
          end else begin
            d.addr = req_addr[19:10];
            d.st = st_row;
          end
        end
      end
      st_row: begin
        d.ras_n = 1'b0;
        d.open_row = q.a[19:10];
        d.page_cnt = 32'h0000_0000;
        d.page_open = (q.cmd != cmd_row_refresh);
        d.cnt = (q.cmd == cmd_row_refresh) ? ras_low_cyc : row_addr_cyc;
        d.st = (q.cmd == cmd_row_refresh) ? st_ras_high : st_col;
        if (q.cmd == cmd_row_refresh) begin
          d.test = 1'b0;
        end
      end
      st_col: begin
        // address, strobes and data settle before the column strobe falls
        d.addr = q.a[9:0];
        d.we_n = (q.cmd != cmd_write); // write strobe only early or late, never between
        d.oe_n = (q.cmd == cmd_write);
        d.dq_out = q.wd;
        d.dq_drive = (q.cmd == cmd_write);
        if (q.cnt == '0) begin
          d.st = st_cas_low;
          d.cas_n = 1'b0;
          d.cnt = cas_low_cyc;
          d.rmw_cnt = rmw_total_cyc;
        end
      end
      st_cas_low: begin
        if (q.cnt == '0) begin
          if (q.cmd == cmd_rmw) begin
            d.rsp_valid = 1'b1;
            d.rsp_rdata = dq_in;
            d.oe_n = 1'b1;
            d.cnt = rmw_write_cyc;
            d.st = st_rmw_wait;
          end else if (q.cmd == cmd_write) begin
            d.cnt = write_hold_cyc;
            d.st = st_write_hold;
          end else begin
            d.rsp_valid = 1'b1;
            d.rsp_rdata = dq_in;
            d.cas_n = 1'b1;
            d.oe_n = 1'b1;
            d.cnt = cas_high_cyc;
            d.st = st_cas_high;
          end
        end
      end
      st_rmw_wait: begin
        // outputs already off, so drive modified data, then a late write strobe
        d.dq_out = q.rsp_rdata ^ q.mask;
        d.dq_drive = 1'b1;
        if (q.cnt == '0) begin
          d.we_n = 1'b0;
          d.cnt = write_hold_cyc;
          d.st = st_write_hold;
        end
      end
      st_write_hold: begin
        if (q.cnt == '0 && (q.cmd != cmd_rmw || q.rmw_cnt == '0)) begin
          d.we_n = 1'b1;
          d.cas_n = 1'b1;
          d.oe_n = 1'b1;
          d.dq_drive = 1'b0;
          d.cnt = cas_high_cyc;
          d.st = st_cas_high;
          if (q.cmd == cmd_rmw) begin
            d.ras_n = 1'b1;
            d.page_open = 1'b0;
            d.cnt = ras_pre_cyc;
            d.st = st_ras_high;
          end
        end
      end
      st_cas_high: begin
        if (q.cnt == '0) begin
          d.st = st_idle;
        end
      end
      st_ref_setup: begin
        if (q.cnt == '0) begin
          d.ras_n = 1'b0;
          d.cnt = refresh_hold_cyc;
          d.st = st_ref_hold;
          d.test = (q.cmd == cmd_test_enter) || (q.test && !q.we_n);
          if (q.init_left != 4'h0) begin
            d.init_left = q.init_left - 4'h1;
          end
          if (q.refreshing) begin
            d.ref_due = (q.ref_timer == 32'h0000_0000); // a request landing now beats the clear
          end
        end
      end
      st_ref_hold: begin
        if (q.cnt == '0) begin
          d.cas_n = 1'b1;
          d.we_n = 1'b1;
          d.cnt = ras_low_cyc;
          d.st = st_ras_high;
        end
      end
      st_ras_high: begin
        if (q.cnt == '0) begin
          if (!q.ras_n) begin
            d.ras_n = 1'b1;
            d.cnt = ras_pre_cyc;
          end else begin
            d.refreshing = 1'b0;
            d.st = st_idle;
          end
        end
      end
      default: d.st = st_idle;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= st_pause;
      q.ras_n <= 1'b1;
      q.cas_n <= 1'b1;
      q.we_n <= 1'b1;
      q.oe_n <= 1'b1;
      q.ref_timer <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end
endmodule

/* dram_dev_model.sv */
// dram device model: strobe-driven 1m x 4 memory with refresh counter and test mode
module dram_dev_model (
  input wire logic ras_n, // row strobe
  input wire logic cas_n, // column strobe
  input wire logic we_n, // write strobe
  input wire logic oe_n, // output gate
  input wire logic [9:0] addr, // multiplexed address
  input wire logic [3:0] din, // resolved data lines
  input wire logic [31:0] acc_ns, // access delay, prompt or slow
  output logic [3:0] dq, // device data, inverse of last when off
  output logic tm, // test mode held
  output int counter_refreshes, // column-first refreshes seen
  output int row_refreshes, // row-only refreshes seen
  output int faults // host mistakes seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] mem [logic [19:0]];
  logic [9:0] row;
  logic [9:0] ref_row = 10'h000;
  logic [19:0] key;
  logic [3:0] rd_v = 4'h0;
  logic refr = 1'b0;
  logic col_seen = 1'b0;
  logic ras_seen = 1'b0;
  logic drive = 1'b0;
  initial begin
    tm = 1'b0;
    counter_refreshes = 0;
    row_refreshes = 0;
    faults = 0;
  end
  // row strobe fall: latch row, or refresh from the internal counter
  always @(negedge ras_n) begin
    col_seen = 1'b0;
    ras_seen = 1'b1;
    refr = !cas_n;
    row = addr;
    if (refr) begin
      counter_refreshes++;
      ref_row = ref_row + 10'h001;
      tm = !we_n; // write strobe low enters or keeps test mode
    end
  end
  // a row cycle with no column access was a row-only refresh
  // the rise out of reset is not a row cycle
  always @(posedge ras_n) if (ras_seen && !refr && !col_seen) begin
    row_refreshes++;
    tm = 1'b0;
    if (counter_refreshes < 8) faults++; // internal counter needs all-counter init
  end
  // column strobe fall: early write stores now, else a read is launched
  always @(negedge cas_n) if (!ras_n) begin
    col_seen = 1'b1;
    key = {row, addr};
    if (counter_refreshes < 8) faults++; // access before init done
    if (!we_n) mem[key] = din; // data taken at column strobe
    else begin
      rd_v = mem.exists(key) ? mem[key] : 4'h0;
      if (tm) rd_v = {1'b0, rd_v == 4'h0 || rd_v == 4'hF, 2'b00}; // agree flag on result line
      #(acc_ns + (tm ? 5 : 0)); // test reads come later
      drive = !cas_n;
    end
  end
  // late write strobe: delayed write or read-modify-write
  always @(negedge we_n) if (!ras_n && !cas_n) begin
    if (!oe_n) faults++; // gate must be off before host data
    mem[key] = din; // data taken at write strobe
  end
  always @(posedge cas_n) drive = 1'b0;
  // off unless column strobe and gate low; inverse shows a stale read
  assign dq = (drive && !cas_n && !oe_n) ? rd_v : ~rd_v;
endmodule

/* dram_host_props.sv */
// checker: strobe timing relations at the dram host controller pins
module dram_host_props (
  input wire logic clk, // clock
  input wire logic rst_n, // sync reset, active low
  input wire logic busy, // init or refresh
  input wire logic test_mode, // test mode held
  input wire logic ras_n, // row strobe
  input wire logic cas_n, // column strobe
  input wire logic we_n, // write strobe
  input wire logic oe_n, // output gate
  input wire logic [3:0] dq_oe // data drive enables
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  int ras_cyc_q;
  int low_q;
  logic late_q;
  // cycle counts since row strobe fell and while it stays low; late write flag per row cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ras_cyc_q <= 0;
      low_q <= 0;
      late_q <= 1'b0;
    end else begin
      ras_cyc_q <= $fell(ras_n) ? 1 : ras_cyc_q + 1;
      low_q <= ras_n ? 0 : low_q + 1;
      late_q <= $fell(ras_n) ? 1'b0 : (late_q | (!ras_n && !cas_n && $fell(we_n)));
    end
  end
  reset_idle_a: assert property (disable iff (1'b0) !rst_n |=> ras_n && cas_n && dq_oe == 4'h0 && busy)
    else $error("strobes not idle after reset");
  refresh_order_a: assert property ($fell(ras_n) && !cas_n |-> !$past(cas_n) ##1 !cas_n)
    else $error("column strobe setup or hold short in refresh");
  cas_precharge_a: assert property ($rose(cas_n) && !ras_n |=> cas_n)
    else $error("column strobe precharge too short");
  data_gate_a: assert property (dq_oe != 4'h0 |-> oe_n)
    else $error("host drives data with output gate on");
  early_write_a: assert property ($fell(cas_n) && !ras_n && !we_n |-> dq_oe == 4'hF ##1 dq_oe == 4'hF)
    else $error("early write data not held at column strobe");
  late_write_a: assert property ($fell(we_n) && !cas_n && !ras_n |-> !$past(cas_n, 3) && !$past(ras_n, 5))
    else $error("late write strobe too early");
  rmw_cycle_a: assert property ($fell(ras_n) && late_q |-> ras_cyc_q >= 9)
    else $error("read-modify-write cycle too short");
  page_width_a: assert property (low_q < 4000)
    else $error("row strobe low too long");
  test_entry_a: assert property ($fell(ras_n) && !cas_n && !we_n |=> !we_n ##[0:12] test_mode)
    else $error("test entry refresh mishandled");
  test_exit_a: assert property ($fell(ras_n) && !cas_n && we_n |-> ##[1:12] !test_mode)
    else $error("plain refresh left test mode on");
  rmw_seen_c: cover property ($fell(ras_n) && late_q);
  test_seen_c: cover property ($rose(test_mode));
  page_seen_c: cover property ($rose(cas_n) && !ras_n ##[1:12] $fell(cas_n) && !ras_n);
endmodule
bind dram_host dram_host_props i_dram_host_props (.clk(clk), .rst_n(rst_n), .busy(busy), .test_mode(test_mode),
  .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .dq_oe(dq_oe));

/* tb_top.sv */
// testbench: dram host controller against the behavioural dram model
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dram_host_pkg::*;
  localparam int gap_c = 200;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready, rsp_valid, busy, test_mode, ras_n, cas_n, we_n, oe_n, dev_tm;
  cmd_e req_cmd = cmd_read;
  logic [19:0] req_addr = 20'h0_0000;
  logic [3:0] req_wdata = 4'h0, req_mask = 4'h0, rsp_rdata, dq_out, dq_oe, dq_in, dev_dq, rd;
  logic [9:0] addr;
  logic [31:0] acc_ns = 32'h0000_0028;
  int faults, refs, row_refs, first_ras = 0, bad_count = 0, checked = 0, cyc = 0;
  always #12.5 clk = ~clk;
  // wire level: host wins where it drives, else the device
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & dev_dq);
  dram_host #(.init_pause_p(20), .refresh_gap_p(gap_c), .page_limit_p(30)) i_dram_host (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_mask(req_mask), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy), .test_mode(test_mode),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in));
  dram_dev_model i_dram_dev_model (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
    .din(dq_in), .acc_ns(acc_ns), .dq(dev_dq), .tm(dev_tm), .counter_refreshes(refs), .row_refreshes(row_refs),
    .faults(faults));
  // cycle count, first row strobe and hang limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  always @(negedge ras_n) if (first_ras == 0) first_ras = cyc;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // request held until ready is seen at a falling edge, then dropped after the next rising edge
  task automatic do_req(input cmd_e c, input logic [19:0] a, input logic [3:0] w, input logic [3:0] m);
    logic rdy;
    rdy = 1'b0;
    @(posedge clk);
    #2;
    req_cmd = c;
    req_addr = a;
    req_wdata = w;
    req_mask = m;
    req_valid = 1'b1;
    while (rdy !== 1'b1) begin
      @(negedge clk);
      rdy = req_ready;
      @(posedge clk);
    end
    #2;
    req_valid = 1'b0;
  endtask
  task automatic read(input logic [19:0] a, input logic [3:0] m, input cmd_e c, input logic [3:0] exp);
    do_req(c, a, 4'h0, m);
    do @(negedge clk); while (rsp_valid !== 1'b1);
    rd = rsp_rdata;
    check(rd, exp);
  endtask
  task automatic wait_tm(input logic v);
    int n;
    n = 0;
    while (test_mode !== v && n < 40) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_init();
    check(busy, 1'b1);
    while (busy !== 1'b0) @(negedge clk);
    check(first_ras >= 30, 1'b1);
    check(refs >= 8, 1'b1);
    $display("init test done");
  endtask
  task automatic t_page();
    do_req(cmd_write, 20'h1_2345, 4'hA, 4'h0);
    do_req(cmd_write, 20'h1_2346, 4'h5, 4'h0);
    do_req(cmd_write, 20'hF_FC00, 4'h3, 4'h0);
    acc_ns = 32'h0000_000A;
    read(20'h1_2345, 4'h0, cmd_read, 4'hA);
    acc_ns = 32'h0000_0028;
    read(20'h1_2346, 4'h0, cmd_read, 4'h5);
    read(20'h0_0000, 4'h0, cmd_read, 4'h0);
    read(20'hF_FC00, 4'h0, cmd_read, 4'h3);
    $display("page test done");
  endtask
  task automatic t_rmw();
    do_req(cmd_write, 20'h5_5555, 4'h6, 4'h0);
    read(20'h5_5555, 4'h3, cmd_rmw, 4'h6);
    read(20'h5_5555, 4'h0, cmd_read, 4'h5);
    $display("rmw test done");
  endtask
  task automatic t_test();
    int c0;
    do_req(cmd_test_enter, 20'h0_0000, 4'h0, 4'h0);
    wait_tm(1'b1);
    check({test_mode, dev_tm}, 2'b11);
    read(20'h0_0000, 4'h0, cmd_read, 4'h4);
    read(20'h1_2345, 4'h0, cmd_read, 4'h0);
    c0 = refs;
    repeat (2 * gap_c + 40) @(posedge clk);
    check(refs - c0 >= 2, 1'b1);
    check({test_mode, dev_tm}, 2'b11);
    do_req(cmd_test_exit, 20'h0_0000, 4'h0, 4'h0);
    wait_tm(1'b0);
    check({test_mode, dev_tm}, 2'b00);
    c0 = row_refs;
    do_req(cmd_row_refresh, 20'h2_A800, 4'h0, 4'h0);
    repeat (12) @(negedge clk);
    check(row_refs, c0 + 1);
    check(faults, 0);
    $display("test mode test done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #2;
    rst_n = 1'b1;
    t_init();
    t_page();
    t_rmw();
    t_test();
    complete_run();
  end
endmodule
